/* core/prsq_pkg.sv */
// Purpose: Constants and types for the power-up and reset sequencer
// Assumes: 100 MHz system clock
// Notes: Times kept in their own units, cycle counts derived
package prsq_pkg;
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned INIT_WAIT_TIME_US = 150;
  localparam int unsigned INIT_WAIT_CYC = (INIT_WAIT_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CFG0_DEFAULT = 16'h8F1F;
  localparam logic [15:0] CFG1_DEFAULT = 16'h0002;
  localparam logic [11:0] ROW_DEFAULT = 12'h000;
  localparam logic [11:0] ROW_LAST = 12'hFFF;

  typedef enum logic [2:0] {
    PRSQ_RESET = 3'h0,
    PRSQ_INIT = 3'h1,
    PRSQ_STANDBY = 3'h2,
    PRSQ_HSLEEP = 3'h3,
    PRSQ_DPD = 3'h4
  } prsq_state_t;

  typedef struct packed {
    logic [15:0] cfg0;
    logic [15:0] cfg1;
  } prsq_cfg_t;
endpackage

/* core/prsq_top.sv */
// Purpose: Power-up initialization and hardware reset sequencing of a self-refreshing DRAM
// Assumes: RESET_N pin is asynchronous to CLOCK; RST_N is the power-on reset from the voltage sensor
// Notes: Low-power entry requests and config writes come from neighbouring logic on CLOCK
// Behaviour
// - After power is stable the device self-initializes by refreshing the array for up to 150 us, then is ready.
// - With hardware reset held low at power-up, the initialization wait starts only once reset goes high.
// - Hardware reset low returns the device to standby from any operation or mode; here it enters PRSQ_RESET and reruns init before standby.
// - Hardware reset restores every configuration register to its default.
// - While reset is low self-refresh stops, array data is invalid and the row counter goes to its default.
// - Hardware reset forces exit from hybrid sleep and deep power-down.
// - When reset returns high self-refresh resumes from the default row counter.
`timescale 1ns/1ps
`default_nettype none
module prsq_top #(
  parameter int unsigned INIT_CYCLES = prsq_pkg::INIT_WAIT_CYC
) (
  input wire logic CLOCK, // System clock, 100 MHz
  input wire logic RST_N, // Power-on reset, active low
  input wire logic RESET_N, // Hardware reset pin, active low
  input wire logic HSLEEP_REQ, // Request to enter hybrid sleep
  input wire logic DPD_REQ, // Request to enter deep power-down
  input wire logic WAKE_REQ, // Request to leave a low-power state
  input wire logic CFG_WE, // Configuration write strobe
  input wire prsq_pkg::prsq_cfg_t CFG_WDATA, // Configuration write data
  output var prsq_pkg::prsq_cfg_t CFG, // Current configuration
  output logic READY, // Initialization done, accesses allowed
  output logic REFRESH_EN, // Self-refresh running
  output logic ARRAY_VALID, // Array contents considered valid
  output logic [11:0] ROW_CNT, // Self-refresh row counter
  output var prsq_pkg::prsq_state_t STATE // Sequencer state
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: three stages, change accepted when stages two and three agree
  // A pin glitch shorter than one cycle is dropped, at the price of a four-cycle lag
  logic s1_r, s2_r, s3_r, rst_pin_r;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      rst_pin_r <= 1'b0;
    end else begin
      s1_r <= RESET_N;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        rst_pin_r <= s3_r;
      end
    end
  end
  wire hw_rst = !rst_pin_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  // Init is run again after every hardware reset, so READY stays low until it ends
  prsq_pkg::prsq_state_t state_r, state_nxt;
  logic [prsq_pkg::CNT_W-1:0] cnt_r;
  logic valid_r;
  logic [11:0] row_r;
  prsq_pkg::prsq_cfg_t cfg_r;
  wire init_done = (cnt_r == prsq_pkg::CNT_W'(INIT_CYCLES - 1));
  wire refreshing = (state_r != prsq_pkg::PRSQ_RESET) && (state_r != prsq_pkg::PRSQ_DPD);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      // Wait held off until reset pin is high
      prsq_pkg::PRSQ_RESET: if (!hw_rst) begin
        state_nxt = prsq_pkg::PRSQ_INIT;
      end
      prsq_pkg::PRSQ_INIT: if (init_done) begin
        state_nxt = prsq_pkg::PRSQ_STANDBY;
      end
      prsq_pkg::PRSQ_STANDBY: begin
        if (DPD_REQ) begin
          state_nxt = prsq_pkg::PRSQ_DPD;
        end else if (HSLEEP_REQ) begin
          state_nxt = prsq_pkg::PRSQ_HSLEEP;
        end
      end
      prsq_pkg::PRSQ_HSLEEP, prsq_pkg::PRSQ_DPD: if (WAKE_REQ) begin
        state_nxt = prsq_pkg::PRSQ_STANDBY;
      end
      default: state_nxt = prsq_pkg::PRSQ_RESET;
    endcase
    // Hardware reset overrides every state
    if (hw_rst) begin
      state_nxt = prsq_pkg::PRSQ_RESET;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= prsq_pkg::PRSQ_RESET;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      // Runs only in INIT, so every entry starts again from zero
      cnt_r <= (state_r == prsq_pkg::PRSQ_INIT) ? cnt_r + 1'b1 : '0;
    end
  end

  // Row counter held at default in reset, restarts from it on release
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      row_r <= prsq_pkg::ROW_DEFAULT;
    end else if (hw_rst) begin
      row_r <= prsq_pkg::ROW_DEFAULT;
    end else if (refreshing) begin
      row_r <= (row_r == prsq_pkg::ROW_LAST) ? prsq_pkg::ROW_DEFAULT : row_r + 1'b1;
    end
  end

  // Array only valid once a full initialization pass completes; deep power-down loses it
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      valid_r <= 1'b0;
    end else if (hw_rst || state_r == prsq_pkg::PRSQ_DPD) begin
      valid_r <= 1'b0;
    end else if (state_r == prsq_pkg::PRSQ_INIT && init_done) begin
      valid_r <= 1'b1;
    end
  end

  // Configuration defaults on any reset; writes ignored until ready
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= {prsq_pkg::CFG0_DEFAULT, prsq_pkg::CFG1_DEFAULT};
    end else if (hw_rst) begin
      cfg_r <= {prsq_pkg::CFG0_DEFAULT, prsq_pkg::CFG1_DEFAULT};
    end else if (CFG_WE && state_r == prsq_pkg::PRSQ_STANDBY) begin
      cfg_r <= CFG_WDATA;
    end
  end

  // READY and REFRESH_EN decoded from the state register; other outputs straight from flops
  assign CFG = cfg_r;
  assign READY = (state_r == prsq_pkg::PRSQ_STANDBY);
  assign REFRESH_EN = refreshing;
  assign ARRAY_VALID = valid_r;
  assign ROW_CNT = row_r;
  assign STATE = state_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Cycles since the filtered pin last read low, kept apart from cnt_r
  // so that the init span check does not lean on the counter it judges
  logic [prsq_pkg::CNT_W-1:0] since_rel_r;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      since_rel_r <= '0;
    end else if (hw_rst) begin
      since_rel_r <= '0;
    end else if (since_rel_r != '1) begin
      since_rel_r <= since_rel_r + 1'b1;
    end
  end

  sequence s_release;
    $fell(hw_rst) && state_r == prsq_pkg::PRSQ_RESET;
  endsequence
  sequence s_restart;
    state_r == prsq_pkg::PRSQ_INIT ##1 REFRESH_EN && row_r == 12'h001;
  endsequence
  sequence s_init_exit;
    $rose(state_r == prsq_pkg::PRSQ_STANDBY) && $past(state_r) == prsq_pkg::PRSQ_INIT;
  endsequence

  // Reset pin and the effects of a hardware reset
  a_filter_agree: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !$stable(rst_pin_r) |-> $past(s2_r) == $past(s3_r) && rst_pin_r == $past(s3_r))
    else $error("pin change accepted without agreement");
  a_reset_forces_state: assert property (@(posedge CLOCK) disable iff (!RST_N)
    hw_rst |=> state_r == prsq_pkg::PRSQ_RESET)
    else $error("reset did not force reset state");
  a_hold_until_high: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_r == prsq_pkg::PRSQ_RESET && hw_rst) |=> state_r == prsq_pkg::PRSQ_RESET)
    else $error("init started while reset low");
  a_reset_exits_lowpwr: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (hw_rst && state_r == prsq_pkg::PRSQ_DPD) |=> !REFRESH_EN && state_r != prsq_pkg::PRSQ_DPD)
    else $error("low-power state survived reset");
  a_reset_exits_sleep: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (hw_rst && state_r == prsq_pkg::PRSQ_HSLEEP) |=> state_r == prsq_pkg::PRSQ_RESET && !REFRESH_EN)
    else $error("hybrid sleep survived reset");
  a_reset_cfg_default: assert property (@(posedge CLOCK) disable iff (!RST_N)
    hw_rst |=> cfg_r == {prsq_pkg::CFG0_DEFAULT, prsq_pkg::CFG1_DEFAULT})
    else $error("config not restored");
  a_reset_row_stop: assert property (@(posedge CLOCK) disable iff (!RST_N)
    hw_rst |=> row_r == prsq_pkg::ROW_DEFAULT && !valid_r && !REFRESH_EN)
    else $error("refresh not halted in reset");

  // Release and initialization
  a_release_resume: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_release |=> s_restart)
    else $error("refresh did not resume from default row");
  a_row_advance: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (REFRESH_EN && !hw_rst && row_r != prsq_pkg::ROW_LAST) |=> row_r == $past(row_r) + 12'h001)
    else $error("row counter did not advance");
  a_init_length: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_init_exit |-> $past(cnt_r) == prsq_pkg::CNT_W'(INIT_CYCLES - 1))
    else $error("init wait length wrong");
  a_init_span: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_init_exit |-> since_rel_r == prsq_pkg::CNT_W'(INIT_CYCLES + 1))
    else $error("init span from release wrong");
  a_init_not_ready: assert property (@(posedge CLOCK) disable iff (!RST_N)
    state_r == prsq_pkg::PRSQ_INIT |-> !READY && !valid_r)
    else $error("ready during init");
  a_init_refresh: assert property (@(posedge CLOCK) disable iff (!RST_N)
    state_r == prsq_pkg::PRSQ_INIT |-> REFRESH_EN)
    else $error("no refresh during init");
  a_init_valid: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_init_exit |-> valid_r)
    else $error("array not valid after init");
endmodule // prsq_top
`default_nettype wire

/* testbench/prsq_host.sv */
// Purpose: Host model driving the hardware reset pin
// Assumes: 100 MHz clock, counts kept in whole cycles
// Notes: No chip select exists at the block; sel_ok marks when one would be allowed
`timescale 1ns/1ps
`default_nettype none
module prsq_host #(
  parameter int PULSE = 20,
  parameter int GAP = 20,
  parameter int INIT = 15000
) (
  input wire logic clock, // System clock
  input wire logic hold, // Keep reset low, power-up or supply dip
  input wire logic go, // Start one reset pulse
  output logic reset_n, // Hardware reset to the device
  output logic sel_ok // Chip select may now go low
);
  int cnt = 0;
  int wait_cnt = 0;
  // Power-up wait restarts for as long as supply or reset is still held
  always @(posedge clock) begin
    if (hold) begin
      wait_cnt <= INIT;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
  // 20 cycles of 10 ns cover each 200 ns minimum, rounded up
  always @(posedge clock) begin
    if (go) begin
      cnt <= PULSE + GAP;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign reset_n = !(hold || cnt > GAP);
  assign sel_ok = reset_n && cnt == 0 && wait_cnt == 0;
endmodule // prsq_host
`default_nettype wire

/* testbench/tb.sv */
// Purpose: Self-checking bench for the power-up and reset sequencer
// Assumes: Init count shortened to 20 cycles
// Notes: Mode requests run from a table, reset cases by hand
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic hs; logic dpd; logic wk; prsq_pkg::prsq_state_t st; logic rf;} prsq_row_t;
  logic clock, rst_n, hold, go, hs, dpd, wk, cfg_we, ready, ref_en, valid, sel_ok, reset_n;
  prsq_pkg::prsq_cfg_t cfg_wdata, cfg;
  logic [11:0] row;
  prsq_pkg::prsq_state_t state;
  int num_errors = 0;
  int total_checks = 0;
  prsq_row_t rows [5] = '{'{1, 0, 0, prsq_pkg::PRSQ_HSLEEP, 1}, '{0, 1, 0, prsq_pkg::PRSQ_HSLEEP, 1},
    '{0, 0, 1, prsq_pkg::PRSQ_STANDBY, 1}, '{1, 1, 0, prsq_pkg::PRSQ_DPD, 0}, '{0, 0, 1, prsq_pkg::PRSQ_STANDBY, 1}};
  prsq_top #(.INIT_CYCLES(20)) DUT (.CLOCK(clock), .RST_N(rst_n), .RESET_N(reset_n), .HSLEEP_REQ(hs),
    .DPD_REQ(dpd), .WAKE_REQ(wk), .CFG_WE(cfg_we), .CFG_WDATA(cfg_wdata), .CFG(cfg), .READY(ready),
    .REFRESH_EN(ref_en), .ARRAY_VALID(valid), .ROW_CNT(row), .STATE(state));
  // Host wait covers the shortened init plus the pin filter lag
  prsq_host #(.INIT(25)) host (.clock(clock), .hold(hold), .go(go), .reset_n(reset_n), .sel_ok(sel_ok));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait; READY must not be trusted before it settles
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check("ready", ready, 1);
    check("valid", valid, 1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  initial begin
    #50000;
    num_errors++;
    finish_test();
  end
  initial begin
    {rst_n, go, hs, dpd, wk, cfg_we} = '0;
    hold = 1;
    cfg_wdata = 32'h1234_5678;
    repeat (3) @(posedge clock);
    rst_n <= 1;
    repeat (40) @(negedge clock);
    check("held state", state, prsq_pkg::PRSQ_RESET);
    check("held ready", ready, 0);
    check("held select", sel_ok, 0);
    @(posedge clock) hold <= 0;
    repeat (10) @(negedge clock);
    check("init select", sel_ok, 0);
    wait_ready();
    check("ready select", sel_ok, 1);
    check("cfg default", cfg, {prsq_pkg::CFG0_DEFAULT, prsq_pkg::CFG1_DEFAULT});
    $display("Power-up test done");
    foreach (rows[i]) begin
      @(posedge clock) {hs, dpd, wk} <= {rows[i].hs, rows[i].dpd, rows[i].wk};
      @(posedge clock) {hs, dpd, wk} <= 3'h0;
      @(negedge clock);
      check("row state", state, rows[i].st);
      check("row refresh", ref_en, rows[i].rf);
    end
    $display("Mode table done");
    @(posedge clock) cfg_we <= 1;
    @(posedge clock) cfg_we <= 0;
    @(posedge clock) dpd <= 1;
    @(posedge clock) dpd <= 0;
    @(negedge clock) check("cfg write", cfg, 32'h1234_5678);
    check("dpd", state, prsq_pkg::PRSQ_DPD);
    @(posedge clock) go <= 1;
    @(posedge clock) go <= 0;
    repeat (12) @(negedge clock);
    check("rst state", state, prsq_pkg::PRSQ_RESET);
    check("rst cfg", cfg, {prsq_pkg::CFG0_DEFAULT, prsq_pkg::CFG1_DEFAULT});
    check("rst row", row, prsq_pkg::ROW_DEFAULT);
    check("rst valid", valid, 0);
    check("rst refresh", ref_en, 0);
    for (int n = 0; n < 40 && state !== prsq_pkg::PRSQ_INIT; n++) @(negedge clock);
    check("resume", ref_en, 1);
    check("row start", row, prsq_pkg::ROW_DEFAULT);
    @(negedge clock) check("row resume", row, 12'h001);
    wait_ready();
    check("select ok", sel_ok, 1);
    $display("Hardware reset test done");
    @(posedge clock) cfg_we <= 1;
    @(posedge clock) cfg_we <= 0;
    @(negedge clock) check("cfg rewrite", cfg, 32'h1234_5678);
    @(posedge clock) rst_n <= 0;
    repeat (3) @(posedge clock);
    rst_n <= 1;
    @(negedge clock);
    check("por state", state, prsq_pkg::PRSQ_RESET);
    check("por cfg", cfg, {prsq_pkg::CFG0_DEFAULT, prsq_pkg::CFG1_DEFAULT});
    wait_ready();
    $display("Power-on reset test done");
    @(posedge clock) hs <= 1;
    @(posedge clock) hs <= 0;
    @(negedge clock) check("sleep", state, prsq_pkg::PRSQ_HSLEEP);
    @(posedge clock) go <= 1;
    @(posedge clock) go <= 0;
    repeat (12) @(negedge clock);
    check("sleep exit", state, prsq_pkg::PRSQ_RESET);
    check("sleep refresh", ref_en, 0);
    check("sleep valid", valid, 0);
    $display("Sleep reset test done");
    finish_test();
  end
endmodule // tb
`default_nettype wire
